// ==== hdl/ccu_capture_compare_unit.sv ====
// Capture and compare unit with an AHB-Lite register slave and a level interrupt.
// Assumes the timebase and its update strobe come from logic on clk; pin inputs are asynchronous.
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps

// What this block does
// - Capture copies all sixteen timebase bits into the value register at once.
// - Mode picks any edge, falling, rising, fourth rising or sixteenth rising edge.
// - Input select picks unit pin, comparator one, comparator two or pin-change trigger.
// - Every capture sets the event flag; only software clears it.
// - A newer capture overwrites an unread stored value.
// - Prescaler counter clears when disabled, not capturing, or in reset.
// - Changing prescale keeps the counter; software should disable first.
// - Each capture pulses the event output for one clock; captures on adjacent clocks merge into a longer pulse.
// - Compare mode matches the value register against the timebase on each update.
// - A match toggles, sets, clears, pulses or only flags; may reset the timebase.
// - Toggle, set and clear modes set the event flag in the cycle the output action applies.
// - Capture works while the timebase is held or runs from an outside clock.
// - Pulse mode follows equality; soft, toggle, clear, set act on a match.
// - Soft event mode never drives the pin, it only raises the flag.
module ccu_capture_compare_unit
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hsel,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [15:0] timebase,
   input wire logic timebase_update,
   output logic timebase_reset,
   input wire logic unit_pin_in,
   output logic unit_pin_out,
   output logic unit_pin_oe_n,
   input wire logic comparator_one_sync,
   input wire logic comparator_two_sync,
   input wire logic pin_change_trigger,
   output logic event_out,
   output logic irq
);
   import ccu_pkg::*;

   // ****************************************
   // Bus slave
   // ****************************************
   logic [7:0] unit_control_reg, next_unit_control_reg;
   logic [1:0] input_select_reg, next_input_select_reg;
   logic [15:0] value_reg, next_value_reg;
   logic event_flag, next_event_flag;
   logic event_irq_enable, next_event_irq_enable;
   logic wr_pend, next_wr_pend;
   logic [7:0] wr_addr, next_wr_addr;
   logic [31:0] next_hrdata;
   logic [3:0] pre_cnt, next_pre_cnt;
   logic out_q, next_out_q;
   logic ev_q, next_ev_q;
   logic [3:0] raw_in, sync_a, next_sync_a, sync_b, next_sync_b;
   logic in_prev, next_in_prev;
   ccu_mode_t mode;
   logic enabled, capturing, comparing, rise, fall, cap_edge, capture, match, match_now;

   // Decoding of a mode into its capture class, shared by several paths.
   function automatic logic is_capture(input ccu_mode_t m);
      is_capture = (m >= CCU_M_CAP_ANY) && (m <= CCU_M_CAP_RISE16);
   endfunction

   assign mode = ccu_mode_t'(unit_control_reg[CCU_CTL_MODE_LO +: 4]);
   assign enabled = unit_control_reg[CCU_CTL_EN];
   assign capturing = enabled && is_capture(mode);
   assign comparing = enabled && (mode != CCU_M_OFF) && !is_capture(mode);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ****************************************
   // Capture input path
   // ****************************************
   logic sel_in;
   always_comb
   begin
      case (input_select_reg)
         CCU_SRC_PIN: sel_in = sync_b[0];
         CCU_SRC_CMP1: sel_in = sync_b[1];
         CCU_SRC_CMP2: sel_in = sync_b[2];
         default: sel_in = sync_b[3];
      endcase
   end
   // The first stage feeds only the second so metastability cannot reach edge logic.
   assign raw_in = {pin_change_trigger, comparator_two_sync, comparator_one_sync, unit_pin_in};
   assign next_sync_a = raw_in;
   assign next_sync_b = sync_a;
   assign next_in_prev = sel_in;
   assign rise = sel_in && !in_prev;
   assign fall = !sel_in && in_prev;

   always_comb
   begin
      cap_edge = 1'b0;
      next_pre_cnt = pre_cnt;
      if (!capturing)
         next_pre_cnt = 4'h0;
      else
      begin
         case (mode)
            CCU_M_CAP_ANY: cap_edge = rise || fall;
            CCU_M_CAP_FALL: cap_edge = fall;
            CCU_M_CAP_RISE: cap_edge = rise;
            CCU_M_CAP_RISE4:
            begin
               // Counter is shared across settings, so a switch can fire early.
               cap_edge = rise && (pre_cnt[1:0] == CCU_PRE4_LAST[1:0]);
               if (rise)
                  next_pre_cnt = pre_cnt + 4'h1;
            end
            CCU_M_CAP_RISE16:
            begin
               cap_edge = rise && (pre_cnt == CCU_PRE16_LAST);
               if (rise)
                  next_pre_cnt = pre_cnt + 4'h1;
            end
            default: cap_edge = 1'b0;
         endcase
      end
   end
   // Capture does not wait for a timebase update, so a held or outside-clocked count still works.
   assign capture = capturing && cap_edge;

   // ****************************************
   // Compare path
   // ****************************************
   assign match_now = comparing && (value_reg == timebase);
   assign match = match_now && timebase_update;

   always_comb
   begin
      next_out_q = out_q;
      if (match)
      begin
         case (mode)
            CCU_M_TOGGLE_CLR, CCU_M_TOGGLE: next_out_q = !out_q;
            CCU_M_SET: next_out_q = 1'b1;
            CCU_M_CLEAR: next_out_q = 1'b0;
            default: next_out_q = out_q;
         endcase
      end
      if (mode == CCU_M_OFF || !enabled)
         next_out_q = 1'b0;
   end
   // Pulse mode follows equality live; soft mode leaves the pin undriven.
   assign unit_pin_out = (mode == CCU_M_PULSE) ? match_now : out_q;
   assign unit_pin_oe_n = !(comparing && mode != CCU_M_SOFT);
   assign timebase_reset = match && unit_control_reg[CCU_CTL_TBRST];
   assign next_ev_q = capture;
   assign event_out = ev_q;
   assign irq = event_flag && event_irq_enable;

   // ****************************************
   // Register file
   // ****************************************
   logic take, do_wr;
   assign take = hsel && hready && htrans[1];
   assign do_wr = wr_pend;
   always_comb
   begin
      next_wr_pend = take && hwrite;
      next_wr_addr = take ? haddr[7:0] : wr_addr;
      next_unit_control_reg = unit_control_reg;
      next_input_select_reg = input_select_reg;
      next_value_reg = value_reg;
      next_event_irq_enable = event_irq_enable;
      next_event_flag = event_flag;
      if (do_wr)
      begin
         case (wr_addr)
            CCU_OFF_CONTROL: next_unit_control_reg = hwdata[7:0];
            CCU_OFF_INSEL: next_input_select_reg = hwdata[1:0];
            CCU_OFF_VALUE: next_value_reg = hwdata[15:0];
            CCU_OFF_STATUS: if (hwdata[CCU_ST_EVENT]) next_event_flag = 1'b0;
            CCU_OFF_MASK: next_event_irq_enable = hwdata[CCU_ST_EVENT];
            default: next_event_flag = event_flag;
         endcase
      end
      if (capture)
         next_value_reg = timebase;
      if (capture || match)
         next_event_flag = 1'b1;
      next_hrdata = hrdata;
      if (take && !hwrite)
      begin
         case (haddr[7:0])
            CCU_OFF_CONTROL: next_hrdata = {24'h000000, unit_control_reg};
            CCU_OFF_INSEL: next_hrdata = {30'h00000000, input_select_reg};
            CCU_OFF_VALUE: next_hrdata = {16'h0000, value_reg};
            CCU_OFF_STATUS: next_hrdata = {31'h00000000, event_flag};
            CCU_OFF_MASK: next_hrdata = {31'h00000000, event_irq_enable};
            CCU_OFF_PIN: next_hrdata = {30'h00000000, unit_pin_out, sync_b[0]};
            default: next_hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         unit_control_reg <= CCU_CONTROL_RST;
         input_select_reg <= CCU_INSEL_RST;
         value_reg <= CCU_VALUE_RST;
         event_flag <= 1'b0;
         event_irq_enable <= 1'b0;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h00000000;
         pre_cnt <= 4'h0;
         out_q <= 1'b0;
         ev_q <= 1'b0;
         sync_a <= 4'h0;
         sync_b <= 4'h0;
         in_prev <= 1'b0;
      end
      else
      begin
         unit_control_reg <= next_unit_control_reg;
         input_select_reg <= next_input_select_reg;
         value_reg <= next_value_reg;
         event_flag <= next_event_flag;
         event_irq_enable <= next_event_irq_enable;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         pre_cnt <= next_pre_cnt;
         out_q <= next_out_q;
         ev_q <= next_ev_q;
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         in_prev <= next_in_prev;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence s_capture;
      capture;
   endsequence
   chk_capture_value: assert property (@(posedge clk) disable iff (rst)
      s_capture |=> value_reg == $past(timebase)) else $error("capture value wrong");
   chk_event_pulse: assert property (@(posedge clk) disable iff (rst)
      s_capture |=> event_out ##1 !event_out || $past(capture))
      else $error("event output width wrong");
   chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
      event_flag && !(do_wr && wr_addr == CCU_OFF_STATUS) |=> event_flag)
      else $error("event flag dropped");
   chk_flag_set: assert property (@(posedge clk) disable iff (rst)
      (capture || match) |=> event_flag) else $error("event flag not set");
   chk_pre_clear: assert property (@(posedge clk) disable iff (rst)
      !capturing |=> pre_cnt == 4'h0) else $error("prescaler not cleared");
   chk_soft_pin: assert property (@(posedge clk) disable iff (rst)
      mode == CCU_M_SOFT |-> unit_pin_oe_n) else $error("soft mode drives pin");
   chk_set_match: assert property (@(posedge clk) disable iff (rst)
      match && mode == CCU_M_SET |=> out_q) else $error("set on match failed");
   chk_clear_match: assert property (@(posedge clk) disable iff (rst)
      match && mode == CCU_M_CLEAR |=> !out_q) else $error("clear on match failed");
   chk_edge_sync: assert property (@(posedge clk) disable iff (rst)
      rise && $past(input_select_reg, 2) == input_select_reg
      |-> $past(raw_in[input_select_reg], 2)) else $error("edge not synchronised");
   chk_match_toggle: assert property (@(posedge clk) disable iff (rst)
      enabled && (mode == CCU_M_TOGGLE || mode == CCU_M_TOGGLE_CLR)
      && timebase_update && value_reg == timebase |=> out_q != $past(out_q))
      else $error("toggle on match failed");
   chk_pulse_pin: assert property (@(posedge clk) disable iff (rst)
      enabled && mode == CCU_M_PULSE |-> unit_pin_out == (value_reg == timebase))
      else $error("pulse output wrong");
   chk_pin_release: assert property (@(posedge clk) disable iff (rst)
      !enabled || is_capture(mode) |-> unit_pin_oe_n) else $error("pin driven outside compare");
   chk_value_hold: assert property (@(posedge clk) disable iff (rst)
      !capture && !(do_wr && wr_addr == CCU_OFF_VALUE) |=> $stable(value_reg))
      else $error("value changed without cause");
   // A prescale switch while still capturing keeps the count, so it may fire early.
   sequence s_quiet_switch;
      capturing && !rise ##1 capturing;
   endsequence
   chk_pre_keep: assert property (@(posedge clk) disable iff (rst)
      s_quiet_switch |-> $stable(pre_cnt))
      else $error("prescaler changed without edge");
   chk_fall_only: assert property (@(posedge clk) disable iff (rst)
      capturing && mode == CCU_M_CAP_FALL && !fall |-> !capture)
      else $error("capture without falling edge");
   chk_rise16_gate: assert property (@(posedge clk) disable iff (rst)
      capturing && mode == CCU_M_CAP_RISE16 && pre_cnt != CCU_PRE16_LAST |-> !capture)
      else $error("early sixteenth capture");
   chk_flag_irq: assert property (@(posedge clk) disable iff (rst)
      event_irq_enable && !do_wr && (capture || match) |=> irq)
      else $error("interrupt not raised");
endmodule

// ==== hdl/ccu_pkg.sv ====
// Package for the capture and compare unit: register map, fields and reset values.
// Assumes a 32-bit AHB-Lite register bus and a 16-bit timebase supplied from outside.
package ccu_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] CCU_OFF_CONTROL = 8'h00;
   localparam logic [7:0] CCU_OFF_INSEL = 8'h04;
   localparam logic [7:0] CCU_OFF_VALUE = 8'h08;
   localparam logic [7:0] CCU_OFF_STATUS = 8'h0C;
   localparam logic [7:0] CCU_OFF_MASK = 8'h10;
   localparam logic [7:0] CCU_OFF_PIN = 8'h14;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CCU_CTL_EN = 7;
   localparam int CCU_CTL_OUT = 5;
   localparam int CCU_CTL_TBRST = 4;
   localparam int CCU_CTL_MODE_LO = 0;
   localparam int CCU_ST_EVENT = 0;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] CCU_CONTROL_RST = 8'h00;
   localparam logic [1:0] CCU_INSEL_RST = 2'h0;
   localparam logic [15:0] CCU_VALUE_RST = 16'h0000;
   // ****************************************
   // Modes and input sources
   // ****************************************
   typedef enum logic [3:0] {
      CCU_M_OFF = 4'h0,
      CCU_M_TOGGLE_CLR = 4'h1,
      CCU_M_TOGGLE = 4'h2,
      CCU_M_CAP_ANY = 4'h3,
      CCU_M_CAP_FALL = 4'h4,
      CCU_M_CAP_RISE = 4'h5,
      CCU_M_CAP_RISE4 = 4'h6,
      CCU_M_CAP_RISE16 = 4'h7,
      CCU_M_SET = 4'h8,
      CCU_M_CLEAR = 4'h9,
      CCU_M_SOFT = 4'hA,
      CCU_M_PULSE = 4'hB
   } ccu_mode_t;
   localparam logic [1:0] CCU_SRC_PIN = 2'h0;
   localparam logic [1:0] CCU_SRC_CMP1 = 2'h1;
   localparam logic [1:0] CCU_SRC_CMP2 = 2'h2;
   localparam logic [1:0] CCU_SRC_IOC = 2'h3;
   localparam logic [3:0] CCU_PRE4_LAST = 4'h3;
   localparam logic [3:0] CCU_PRE16_LAST = 4'hF;
endpackage

// ==== tb/ccu_capture_compare_unit_tb.sv ====
// Self-checking bench for the capture and compare unit.
// Assumes the timebase model beside it and a single AHB-Lite slave.
`timescale 1ns/1ps
module ccu_capture_compare_unit_tb;
   import ccu_pkg::*;
   logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hsel = 1'b0, hold = 1'b1, load = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [3:0] srcs = 4'h0;
   logic [15:0] load_val = 16'h0, timebase, rnd;
   logic hready, hreadyout, hresp, tb_upd, tb_rst, pin_out, oe_n, event_out, irq;
   logic rd_vld = 1'b0, prev_evt = 1'b0;
   logic [31:0] exp_q[$];
   int error_cnt = 0, n_checks = 0, evt_n = 0, seed = 19, base, n;
   int md[5] = '{3, 4, 5, 6, 7};
   int nt[5] = '{4, 4, 4, 8, 30};
   int ne[5] = '{4, 2, 2, 1, 0};
   logic [7:0] cm[5] = '{8'h88, 8'h89, 8'h92, 8'h8B, 8'h8A};
   logic ep[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   always #2 clk = ~clk;
   assign hready = hreadyout;
   ccu_timebase_model ccu_timebase_model_i (.clk(clk), .rst(rst), .hold(hold), .load(load),
      .load_val(load_val), .clear(tb_rst), .timebase(timebase), .timebase_update(tb_upd));
   ccu_capture_compare_unit ccu_capture_compare_unit_i (.clk(clk), .rst(rst), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timebase(timebase), .timebase_update(tb_upd), .timebase_reset(tb_rst),
      .unit_pin_in(srcs[0]), .unit_pin_out(pin_out), .unit_pin_oe_n(oe_n),
      .comparator_one_sync(srcs[1]), .comparator_two_sync(srcs[2]),
      .pin_change_trigger(srcs[3]), .event_out(event_out), .irq(irq));
   // ****************************************
   // Tasks
   // ****************************************
   task finish_test;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Waits are bounded so a dead slave ends the run instead of hanging it.
   task wait_rdy;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 64);
      if (n >= 64)
      begin
         error_cnt++;
         finish_test;
      end
   endtask
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      hsel <= 1'b1;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      rd_vld <= !wr;
      if (!wr)
         exp_q.push_back(d);
      wait_rdy;
      rd_vld <= 1'b0;
   endtask
   task cnt(input int s, input int k, input int e);
      base = evt_n;
      repeat (k)
      begin
         @(posedge clk);
         srcs[s] <= ~srcs[s];
         repeat (7) @(posedge clk);
      end
      @(negedge clk);
      chk(evt_n - base, e);
   endtask
   // ****************************************
   // Output watcher
   // ****************************************
   always @(posedge clk)
   begin
      if (rd_vld)
         chk(hrdata, exp_q.pop_front());
      if (event_out)
         chk(prev_evt, 1'b0);
      if (event_out)
         evt_n++;
      prev_evt <= event_out;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      bus(0, CCU_OFF_CONTROL, {24'h0, CCU_CONTROL_RST});
      bus(0, CCU_OFF_VALUE, {16'h0, CCU_VALUE_RST});
      bus(0, 8'h20, 32'h0);
      chk(oe_n, 1'b1);
      bus(1, CCU_OFF_MASK, 32'h1);
      for (int i = 0; i < 5; i++)
      begin
         bus(1, CCU_OFF_CONTROL, 32'h0);
         bus(1, CCU_OFF_CONTROL, 32'h80 | md[i]);
         cnt(0, nt[i], ne[i]);
      end
      cnt(0, 2, 1);
      bus(1, CCU_OFF_CONTROL, 32'h86);
      cnt(0, 6, 0);
      bus(1, CCU_OFF_CONTROL, 32'h0);
      bus(1, CCU_OFF_CONTROL, 32'h86);
      cnt(0, 2, 0);
      cnt(0, 6, 1);
      bus(1, CCU_OFF_CONTROL, 32'h85);
      for (int s = 0; s < 4; s++)
      begin
         bus(1, CCU_OFF_INSEL, s);
         cnt((s + 1) % 4, 2, 0);
         cnt(s, 2, 1);
      end
      bus(1, CCU_OFF_INSEL, {30'h0, CCU_SRC_PIN});
      repeat (2)
      begin
         rnd = 16'($random(seed));
         @(posedge clk);
         load_val <= rnd;
         load <= 1'b1;
         @(posedge clk);
         load <= 1'b0;
         cnt(0, 2, 1);
      end
      bus(0, CCU_OFF_VALUE, {16'h0, rnd});
      bus(0, CCU_OFF_STATUS, 32'h1);
      chk(irq, 1'b1);
      bus(1, CCU_OFF_STATUS, 32'h1);
      bus(0, CCU_OFF_STATUS, 32'h0);
      chk(irq, 1'b0);
      hold <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         rnd = 16'($random(seed)) | 16'h0100;
         bus(1, CCU_OFF_MASK, 32'h0);
         // Clear mode starts from the high output that set mode left behind.
         if (i != 1)
            bus(1, CCU_OFF_CONTROL, 32'h0);
         bus(1, CCU_OFF_VALUE, {16'h0, rnd});
         bus(1, CCU_OFF_CONTROL, {24'h0, cm[i]});
         bus(1, CCU_OFF_STATUS, 32'h1);
         bus(1, CCU_OFF_MASK, 32'h1);
         load_val <= rnd - 16'h0008;
         load <= 1'b1;
         @(posedge clk);
         load <= 1'b0;
         n = 0;
         while (irq !== 1'b1 && n < 200)
         begin
            @(negedge clk);
            n++;
         end
         chk(n < 200, 1'b1);
         if (n >= 200)
            finish_test;
         if (i < 4)
            chk(pin_out, ep[i]);
         chk(oe_n, i == 4);
         chk(timebase, cm[i][4] ? 16'h0000 : rnd);
      end
      finish_test;
   end
endmodule

// ==== tb/ccu_timebase_model.sv ====
// Partner model: the shared 16-bit timebase that feeds the capture and compare unit.
// Assumes one clock; the bench drives hold (sleep), load and load_val.
`timescale 1ns/1ps
module ccu_timebase_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hold,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic clear,
   output logic [15:0] timebase,
   output logic timebase_update
);
   logic [1:0] div;
   // ****************************************
   // Counter
   // ****************************************
   // Counts on clk only, once in four clocks, so pin events are seen.
   // A held count keeps its value and resumes from it.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         div <= 2'h0;
         timebase <= 16'h0000;
         timebase_update <= 1'b0;
      end
      else
      begin
         div <= hold ? div : div + 2'h1;
         timebase_update <= !hold && div == 2'h3;
         if (load)
            timebase <= load_val;
         else if (clear)
            timebase <= 16'h0000;
         else if (!hold && div == 2'h3)
            timebase <= timebase + 16'h0001;
      end
   end
endmodule
